// file: design/vmsc_top.sv
/*
 * vmsc_top: scan pacing, registers and interrupt of the voltage monitor.
 * assumes a converter that takes a one-cycle start with a channel number
 * and later returns a one-cycle done with the 8-bit result.
 */
// How it works
// - settle 40/80/160 us after channel switch
// - rescan enabled channels once per period
// - channel 9 only first of 1024 periods
// - reference select output from config bit 1
// - internal reference if either requester asks
// - config bit 0 set means standby, no conversions
// - bank select 0..10 picks visible channel
// - only enabled channels join the scan
// - store result, set write-one-clear done flag
`timescale 1ns/100ps
module vmsc_top
	import vmsc_pkg::*;
#(
	parameter int unsigned PER_SCALE = CYC_PER_MS // cycles per millisecond
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire vmsc_bus_s    bus,
	output logic [7:0]        rdata,
	input  wire vmsc_result_s adc_res,
	input  wire logic         tms_int_ref,
	output logic              adc_start,
	output logic [3:0]        adc_channel,
	output logic              vref_ext_sel,
	output logic              adc_ref_ext,
	output logic              irq
);

	logic [7:0]        timing_reg;   // delay and period codes
	logic [7:0]        config_reg;   // standby and reference
	logic [7:0]        bank_reg;     // visible channel
	logic [NCH-1:0]    chen_reg;     // per-channel enables
	logic [NCH-1:0]    eoc_reg;      // per-channel new-data flags
	logic [7:0]        reading_reg [NCH]; // last results
	logic [1:0]        ists_reg;     // sticky interrupt status
	logic [1:0]        imsk_reg;     // interrupt mask
	vmsc_state_e       state_reg;
	logic [3:0]        ch_reg;       // channel being handled
	logic [31:0]       per_cnt_reg;  // period timer
	logic [15:0]       dly_cnt_reg;  // settle timer
	logic [9:0]        run_cnt_reg;  // period index within run
	logic              scan_req_reg; // a period elapsed, scan pending
	logic              first_reg;    // scan belongs to first of run
	logic [1:0]        ev_set;       // events this cycle

	// turn a period code into cycles; reserved codes act as the longest
	function automatic logic [31:0] period_cycles(input logic [2:0] code);
		unique case (code)
			3'h1:    period_cycles = 32'(PER1_MS * PER_SCALE);
			3'h2:    period_cycles = 32'(PER2_MS * PER_SCALE);
			3'h3:    period_cycles = 32'(PER3_MS * PER_SCALE);
			3'h4:    period_cycles = 32'(PER4_MS * PER_SCALE);
			3'h5:    period_cycles = 32'(PER5_MS * PER_SCALE);
			default: period_cycles = 32'(PER0_MS * PER_SCALE);
		endcase
	endfunction

	// settle delay code to cycles; reserved codes use the longest delay
	function automatic logic [15:0] delay_cycles(input logic [2:0] code);
		unique case (code)
			3'h0:    delay_cycles = 16'(DLY0_CYC);
			3'h1:    delay_cycles = 16'(DLY1_CYC);
			default: delay_cycles = 16'(DLY2_CYC);
		endcase
	endfunction

	// is a channel part of this scan
	function automatic logic in_scan(input logic [3:0] c,
	                                 input logic [NCH-1:0] en,
	                                 input logic first);
		in_scan = en[c] && ((c != SPECIAL_CH) || first);
	endfunction

	// next scanned channel at or above c, NCH if none
	function automatic logic [3:0] next_ch(input logic [3:0] c,
	                                       input logic [NCH-1:0] en,
	                                       input logic first);
		next_ch = 4'(NCH);
		for (int i = NCH - 1; i >= 0; i--) begin
			if (4'(i) >= c && in_scan(4'(i), en, first)) begin
				next_ch = 4'(i); // lowest wins, ascending
			end
		end
	endfunction

	wire standby = config_reg[CFG_STBY_BIT];
	wire [3:0] sel_ch = bank_reg[3:0];
	wire bank_ok = (bank_reg[4:0] <= BANK_MAX);

	// software registers; reserved bits forced to zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timing_reg <= RST_TIMING;
			config_reg <= RST_CONFIG;
			bank_reg   <= RST_BANK;
			imsk_reg   <= 2'h0;
		end else if (bus.wr) begin
			unique case (bus.addr)
				OFF_TIMING:  timing_reg <= {2'h0, bus.wdata[5:0]};
				OFF_CONFIG:  config_reg <= {6'h00, bus.wdata[1:0]};
				OFF_BANK:    bank_reg <= {3'h0, bus.wdata[4:0]};
				OFF_IRQ_MSK: imsk_reg <= bus.wdata[1:0];
				default: ;
			endcase
		end
	end

	// channel enables, written through the bank window
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chen_reg <= '0;
		end else if (bus.wr && bus.addr == OFF_CHCFG && bank_ok) begin
			chen_reg[sel_ch] <= bus.wdata[CH_EN_BIT];
		end
	end

	// results and end-of-conversion flags; a new result beats the clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			eoc_reg <= '0;
			for (int i = 0; i < NCH; i++) begin
				reading_reg[i] <= 8'h00;
			end
		end else begin
			if (bus.wr && bus.addr == OFF_CHCFG && bank_ok
			    && bus.wdata[CH_EOC_BIT]) begin
				eoc_reg[sel_ch] <= 1'b0; // write one clears
			end
			if (state_reg == VMSC_CONVERT && adc_res.done) begin
				reading_reg[ch_reg] <= adc_res.data;
				eoc_reg[ch_reg]     <= 1'b1; // set wins
			end
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			unique case (bus.addr)
				OFF_TIMING:  rdata <= timing_reg;
				OFF_CONFIG:  rdata <= config_reg;
				OFF_BANK:    rdata <= bank_reg;
				OFF_CHCFG:   rdata <= bank_ok ? {eoc_reg[sel_ch], 6'h00,
				                        chen_reg[sel_ch]} : 8'h00;
				OFF_READING: rdata <= bank_ok ? reading_reg[sel_ch] : 8'h00;
				OFF_IRQ_STS: rdata <= {6'h00, ists_reg};
				OFF_IRQ_MSK: rdata <= {6'h00, imsk_reg};
				default:     rdata <= 8'h00; // unmapped reads zero
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// period timer counts periods only outside standby, which holds it at zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			per_cnt_reg  <= 32'h0;
			run_cnt_reg  <= 10'h000;
			scan_req_reg <= 1'b0;
			first_reg    <= 1'b1;
		end else if (standby) begin
			per_cnt_reg  <= 32'h0; // standby halts pacing
			scan_req_reg <= 1'b0;
		end else if (per_cnt_reg == 32'h0) begin
			// start of a period: request a scan
			per_cnt_reg  <= period_cycles(timing_reg[2:0]) - 32'h1;
			scan_req_reg <= 1'b1;
			first_reg    <= (run_cnt_reg == 10'h000);
			run_cnt_reg  <= (run_cnt_reg == RUN_LAST) ? 10'h000
			                : run_cnt_reg + 10'h001;
		end else begin
			per_cnt_reg <= per_cnt_reg - 32'h1;
			if (state_reg == VMSC_IDLE) begin
				scan_req_reg <= 1'b0; // taken by the sequencer
			end
		end
	end

	// scan sequencer: settle then convert each enabled channel, channel 9 only in the first period of a run
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg   <= VMSC_IDLE;
			ch_reg      <= 4'h0;
			dly_cnt_reg <= 16'h0;
			adc_start   <= 1'b0;
			adc_channel <= 4'h0;
		end else begin
			adc_start <= 1'b0;
			unique case (state_reg)
				VMSC_IDLE: begin
					if (scan_req_reg && !standby
					    && next_ch(4'h0, chen_reg, first_reg) != 4'(NCH)) begin
						ch_reg      <= next_ch(4'h0, chen_reg, first_reg);
						adc_channel <= next_ch(4'h0, chen_reg, first_reg);
						dly_cnt_reg <= delay_cycles(timing_reg[5:3]);
						state_reg   <= VMSC_SETTLE;
					end
				end
				VMSC_SETTLE: begin
					if (standby) begin
						state_reg <= VMSC_IDLE;
					end else if (dly_cnt_reg == 16'h1) begin
						adc_start <= 1'b1; // one conversion
						state_reg <= VMSC_CONVERT;
					end else begin
						dly_cnt_reg <= dly_cnt_reg - 16'h1;
					end
				end
				VMSC_CONVERT: begin
					if (adc_res.done) begin
						if (!standby && next_ch(ch_reg + 4'h1, chen_reg,
						    first_reg) != 4'(NCH)) begin
							ch_reg      <= next_ch(ch_reg + 4'h1, chen_reg,
							                       first_reg);
							adc_channel <= next_ch(ch_reg + 4'h1, chen_reg,
							                       first_reg);
							dly_cnt_reg <= delay_cycles(timing_reg[5:3]);
							state_reg   <= VMSC_SETTLE;
						end else begin
							state_reg <= VMSC_IDLE;
						end
					end
				end
			endcase
		end
	end

	// events: a channel result, and the end of a scan
	always_comb begin
		ev_set = 2'h0;
		ev_set[IRQ_EOC_BIT] = (state_reg == VMSC_CONVERT) && adc_res.done;
		ev_set[IRQ_SCAN_BIT] = ev_set[IRQ_EOC_BIT]
		    && next_ch(ch_reg + 4'h1, chen_reg, first_reg) == 4'(NCH);
	end

	// sticky status cleared by reading it; a new event survives the read
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ists_reg <= 2'h0;
			irq      <= 1'b0;
		end else begin
			if (bus.rd && bus.addr == OFF_IRQ_STS) begin
				ists_reg <= ev_set;
			end else begin
				ists_reg <= ists_reg | ev_set;
			end
			irq <= |(ists_reg & imsk_reg);
		end
	end

	// reference selection; adc_ref_ext goes internal if either side asks, vref_ext_sel follows config only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vref_ext_sel <= 1'b1;
			adc_ref_ext  <= 1'b1;
		end else begin
			vref_ext_sel <= config_reg[CFG_XREF_BIT];
			adc_ref_ext  <= config_reg[CFG_XREF_BIT] && !tms_int_ref;
		end
	end

	// no start within 8 cycles of entering settle
	settle_before_start_a: assert property (
		@(posedge clk) disable iff (!resetn)
		$rose(state_reg == VMSC_SETTLE) |-> !adc_start [*8])
		else $error("start came before settle time");

	standby_no_start_a: assert property (
		@(posedge clk) disable iff (!resetn)
		$past(standby) && standby |-> !adc_start)
		else $error("conversion started in standby");

	ref_follows_cfg_a: assert property (
		@(posedge clk) disable iff (!resetn)
		##1 vref_ext_sel == $past(config_reg[CFG_XREF_BIT]))
		else $error("reference select does not follow config");

	ref_internal_a: assert property (
		@(posedge clk) disable iff (!resetn)
		tms_int_ref |=> !adc_ref_ext)
		else $error("internal reference not used");

	reserved_zero_a: assert property (
		@(posedge clk) disable iff (!resetn)
		timing_reg[7:6] == 2'h0 && config_reg[7:2] == 6'h00
		&& bank_reg[7:5] == 3'h0)
		else $error("reserved bits set");

	enabled_only_a: assert property (
		@(posedge clk) disable iff (!resetn)
		adc_start |-> chen_reg[adc_channel]
		|| $past(chen_reg[adc_channel], 2))
		else $error("disabled channel converted");

	special_first_a: assert property (
		@(posedge clk) disable iff (!resetn)
		adc_start && adc_channel == SPECIAL_CH |-> first_reg)
		else $error("special channel outside first period");

	eoc_set_a: assert property (
		@(posedge clk) disable iff (!resetn)
		state_reg == VMSC_CONVERT && adc_res.done
		|=> eoc_reg[$past(ch_reg)]
		&& reading_reg[$past(ch_reg)] == $past(adc_res.data))
		else $error("result not stored");

	bank_range_a: assert property (
		@(posedge clk) disable iff (!resetn)
		bus.wr && bus.addr == OFF_BANK
		|=> bank_reg[4:0] == $past(bus.wdata[4:0]))
		else $error("bank select not taken");

	ascending_a: assert property (
		@(posedge clk) disable iff (!resetn)
		adc_res.done && state_reg == VMSC_CONVERT
		&& state_reg == $past(state_reg)
		##1 state_reg == VMSC_SETTLE |-> ch_reg > $past(ch_reg))
		else $error("channel order not ascending");

	period_scan_a: assert property (
		@(posedge clk) disable iff (!resetn)
		!standby && per_cnt_reg == 32'h0 && !$past(standby)
		|=> scan_req_reg)
		else $error("period did not request scan");
endmodule

// file: design/vmsc_pkg.sv
/*
 * vmsc_pkg: constants and types for the voltage monitor scan control.
 * assumes a 20 MHz system clock; offsets are byte addresses on a plain
 * 8-bit register port.
 */
package vmsc_pkg;
	localparam int unsigned CLK_HZ       = 20000000; // system clock rate
	localparam int unsigned NCH          = 11;       // channels 0..10
	localparam logic [3:0]  SPECIAL_CH   = 4'h9;     // rarely scanned channel
	localparam int unsigned SPECIAL_RUN  = 1024;     // periods per special run
	localparam logic [9:0]  RUN_LAST     = 10'h3FF;  // last period in run

	// register offsets
	localparam logic [7:0] OFF_TIMING  = 8'h07;
	localparam logic [7:0] OFF_CONFIG  = 8'h08;
	localparam logic [7:0] OFF_BANK    = 8'h09;
	localparam logic [7:0] OFF_CHCFG   = 8'h0A;
	localparam logic [7:0] OFF_READING = 8'h0B;
	localparam logic [7:0] OFF_IRQ_STS = 8'h10;
	localparam logic [7:0] OFF_IRQ_MSK = 8'h11;

	// reset values
	localparam logic [7:0] RST_TIMING = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h03;
	localparam logic [7:0] RST_BANK   = 8'h00;

	// field positions
	localparam int unsigned CFG_STBY_BIT = 0;
	localparam int unsigned CFG_XREF_BIT = 1;
	localparam int unsigned CH_EN_BIT    = 0;
	localparam int unsigned CH_EOC_BIT   = 7;
	localparam logic [4:0]  BANK_MAX     = 5'h0A;

	// settling delays in microseconds and their cycle counts
	localparam int unsigned DLY0_US = 40;
	localparam int unsigned DLY1_US = 80;
	localparam int unsigned DLY2_US = 160;
	localparam int unsigned DLY0_CYC = (DLY0_US * (CLK_HZ / 1000000));
	localparam int unsigned DLY1_CYC = (DLY1_US * (CLK_HZ / 1000000));
	localparam int unsigned DLY2_CYC = (DLY2_US * (CLK_HZ / 1000000));

	// conversion periods in milliseconds
	localparam int unsigned PER0_MS = 2000;
	localparam int unsigned PER1_MS = 1000;
	localparam int unsigned PER2_MS = 500;
	localparam int unsigned PER3_MS = 100;
	localparam int unsigned PER4_MS = 50;
	localparam int unsigned PER5_MS = 20;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

	// interrupt status bits
	localparam int unsigned IRQ_EOC_BIT  = 0; // a channel finished
	localparam int unsigned IRQ_SCAN_BIT = 1; // a scan finished

	typedef enum logic [1:0] {
		VMSC_IDLE,
		VMSC_SETTLE,
		VMSC_CONVERT
	} vmsc_state_e;

	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} vmsc_bus_s;

	// converter result
	typedef struct packed {
		logic       done;
		logic [7:0] data;
	} vmsc_result_s;
endpackage

// file: test/vmsc_adc_model.sv
/*
 * vmsc_adc_model: behavioural shared converter for the scan control bench.
 * assumes one clock, a one-cycle start pulse and a channel that holds.
 */
`timescale 1ns/100ps
module vmsc_adc_model
	import vmsc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       adc_start,
	input  wire logic [3:0] adc_channel,
	output vmsc_result_s    adc_res
);
	logic [3:0] wait_cnt; // cycles left in this conversion
	logic       busy;     // a conversion is under way
	logic       slow;     // alternates prompt and slow answers
	logic [7:0] val;      // result being prepared

	// one result per start; data toggles when no result stands,
	// so a design that samples outside done sees garbage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			adc_res  <= '0;
			busy     <= 1'b0;
			slow     <= 1'b0;
			wait_cnt <= 4'h0;
			val      <= 8'h00;
		end else begin
			adc_res.done <= 1'b0;
			adc_res.data <= ~adc_res.data;
			if (adc_start) begin
				// result encodes the channel so mixups show
				busy     <= 1'b1;
				wait_cnt <= slow ? 4'h7 : 4'h1;
				slow     <= ~slow;
				val      <= 8'h40 + {4'h0, adc_channel};
			end else if (busy && wait_cnt == 4'h0) begin
				busy         <= 1'b0;
				adc_res.done <= 1'b1;
				adc_res.data <= val;
			end else if (busy) begin
				wait_cnt <= wait_cnt - 4'h1;
			end
		end
	end
endmodule

// file: test/test_vmsc_top.sv
/*
 * test_vmsc_top: register, scan pacing and interrupt tests.
 * assumes vmsc_top and the converter model; period scaled by PS.
 */
`timescale 1ns/100ps
module test_vmsc_top;
	import vmsc_pkg::*;
	localparam int PS     = 600;     // cycles per millisecond in sim
	localparam int PERIOD = 20 * PS; // code 101 period in cycles
	logic         clk;
	logic         resetn;
	vmsc_bus_s    bus;
	logic [7:0]   rdata;
	vmsc_result_s adc_res;
	logic         tms_int_ref;
	logic         adc_start;
	logic [3:0]   adc_channel;
	logic         vref_ext_sel;
	logic         adc_ref_ext;
	logic         irq;
	int           err_count;
	int           comparisons;
	int           cyc;      // cycle count
	int           chg;      // cycle of last channel switch
	logic [3:0]   last_ch;  // previous mux channel
	int           st_ch[$]; // channel of each start
	int           st_dly[$];// settle cycles of each start
	int           st_t[$];  // cycle of each start

	vmsc_top #(.PER_SCALE(PS)) i_vmsc_top (.clk(clk), .resetn(resetn),
		.bus(bus), .rdata(rdata), .adc_res(adc_res),
		.tms_int_ref(tms_int_ref), .adc_start(adc_start),
		.adc_channel(adc_channel), .vref_ext_sel(vref_ext_sel),
		.adc_ref_ext(adc_ref_ext), .irq(irq));
	vmsc_adc_model i_vmsc_adc_model (.clk(clk), .resetn(resetn),
		.adc_start(adc_start), .adc_channel(adc_channel),
		.adc_res(adc_res));

	// 20 MHz clock
	always #25 clk = ~clk;

	// logs every start with its settle time since the channel switch
	always @(posedge clk) begin
		cyc++;
		if (adc_channel !== last_ch) chg = cyc;
		last_ch = adc_channel;
		if (adc_start === 1'b1) begin
			st_ch.push_back(adc_channel);
			st_dly.push_back(cyc - chg);
			st_t.push_back(cyc);
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk) bus <= '0;
	endtask

	// one-cycle read, data looked at in the following cycle only
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk) bus <= '0;
		#1 check({8'h00, rdata}, {8'h00, exp});
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// cuts a hang short; tests need about 70000 cycles
	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial begin
		int n;
		int len;
		int expc[5];
		int dcyc[3];
		logic [2:0] dcode[3];
		clk = 1'b0;
		resetn = 1'b0;
		bus = '0;
		tms_int_ref = 1'b0;
		dcyc = '{DLY2_CYC, DLY0_CYC, DLY1_CYC};
		dcode = '{3'h2, 3'h0, 3'h1};
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		rdc(OFF_TIMING, 8'h00);
		rdc(OFF_CONFIG, 8'h03);
		rdc(OFF_BANK, 8'h00);
		rdc(8'h20, 8'h00); // unmapped place reads zero
		check({15'h0, vref_ext_sel}, 16'h0001);
		check({15'h0, adc_ref_ext}, 16'h0001);
		$display("test reset values done");
		// reserved bits never stick
		wr(OFF_TIMING, 8'hFF);
		rdc(OFF_TIMING, 8'h3F);
		wr(OFF_BANK, 8'hFF);
		rdc(OFF_BANK, 8'h1F);
		wr(OFF_CONFIG, 8'hFD);
		rdc(OFF_CONFIG, 8'h01);
		repeat (2) @(posedge clk);
		check({15'h0, vref_ext_sel}, 16'h0000);
		check({15'h0, adc_ref_ext}, 16'h0000);
		wr(OFF_CONFIG, 8'h03);
		tms_int_ref <= 1'b1;
		repeat (3) @(posedge clk);
		check({15'h0, vref_ext_sel}, 16'h0001);
		check({15'h0, adc_ref_ext}, 16'h0000);
		tms_int_ref <= 1'b0;
		repeat (3) @(posedge clk);
		check({15'h0, adc_ref_ext}, 16'h0001);
		$display("test reference select done");
		// bank 31 is reserved: reads zero, writes dropped
		rdc(OFF_CHCFG, 8'h00);
		wr(OFF_CHCFG, 8'h01);
		// enable channels 2, 5 and the rarely scanned 9
		expc = '{2, 5, 9, 0, 0};
		for (int k = 0; k < 3; k++) begin
			wr(OFF_BANK, 8'(expc[k]));
			wr(OFF_CHCFG, 8'h01);
		end
		wr(OFF_BANK, 8'h0A);
		rdc(OFF_CHCFG, 8'h00);
		wr(OFF_BANK, 8'h05);
		rdc(OFF_CHCFG, 8'h01);
		repeat (2000) @(posedge clk);
		check(16'(st_ch.size()), 16'h0000);
		$display("test banks and standby done");
		// two periods per settle code; channel 9 only in very first
		for (int i = 0; i < 3; i++) begin
			n = st_ch.size();
			wr(OFF_TIMING, {2'b00, dcode[i], 3'b101});
			wr(OFF_CONFIG, 8'h02);
			repeat (PERIOD + 10000) @(posedge clk);
			wr(OFF_CONFIG, 8'h03);
			if (i == 0) begin
				expc = '{2, 5, 9, 2, 5};
				len = 5;
			end else begin
				expc = '{2, 5, 2, 5, 0};
				len = 4;
			end
			check(16'(st_ch.size() - n), 16'(len));
			if (st_ch.size() >= n + len) begin
				for (int k = 0; k < len; k++) begin
					check(16'(st_ch[n + k]), 16'(expc[k]));
					check(16'(st_dly[n + k]), 16'(dcyc[i]));
				end
				check(16'(st_t[n + len - 2] - st_t[n]), 16'(PERIOD));
			end
			$display("test scan with settle code %0d done", dcode[i]);
		end
		// stored result, done flag and interrupt
		wr(OFF_BANK, 8'h05);
		rdc(OFF_READING, 8'h45);
		rdc(OFF_CHCFG, 8'h81);
		wr(OFF_CHCFG, 8'h81);
		rdc(OFF_CHCFG, 8'h01);
		check({15'h0, irq}, 16'h0000); // masked events stay quiet
		wr(OFF_IRQ_MSK, 8'h01);
		rdc(OFF_IRQ_MSK, 8'h01); // mask reads back
		check({15'h0, irq}, 16'h0001); // unmasked result raises it
		rdc(OFF_IRQ_STS, 8'h03);
		repeat (2) @(posedge clk);
		check({15'h0, irq}, 16'h0000); // read cleared status
		rdc(OFF_IRQ_STS, 8'h00); // stays clear in standby
		$display("test results and interrupt done");
		tally_and_finish();
	end
endmodule
